/* rtl/dtx_pkg.sv */
/*
  Shared constants and types for the device transmit sequencer: word layouts,
  frame header fields, counter widths and the sequencer state encoding.
  Assumes nothing of its surroundings; every design module imports it whole.
*/
package dtx_pkg;

  // Data, length and word-index widths.
  localparam int DWORD_W = 32;
  localparam int LEN_W   = 16;
  localparam int BIDX_W  = 2;

  // Frame type codes placed in the low byte of the first dword.
  localparam logic [7:0] FRAME_TYPE_DATA = 8'h46;
  localparam logic [7:0] FRAME_TYPE_BIST = 8'h58;

  // Header padding fields.
  localparam logic [23:0] HDR_PAD_DATA = 24'h000000;
  localparam logic [15:0] HDR_PAD_BIST = 16'h0000;

  // Counter values.
  localparam logic [LEN_W-1:0]  LEN_ZERO  = 16'h0000;
  localparam logic [LEN_W-1:0]  LEN_ONE   = 16'h0001;
  localparam logic [BIDX_W-1:0] BIDX_HDR  = 2'h0;
  localparam logic [BIDX_W-1:0] BIDX_HI   = 2'h1;
  localparam logic [BIDX_W-1:0] BIDX_LAST = 2'h2;
  localparam logic [BIDX_W-1:0] BIDX_ONE  = 2'h1;

  // One word toward the link layer, with frame delimiters.
  typedef struct packed {
    logic [DWORD_W-1:0] data;
    logic               first;
    logic               last;
  } dtx_word_t;

  localparam dtx_word_t WORD_NONE = '{data: 32'h00000000, first: 1'b0, last: 1'b0};

  // Self-test activation frame content from the application layer.
  typedef struct packed {
    logic [7:0]         mode;
    logic [DWORD_W-1:0] dataHi;
    logic [DWORD_W-1:0] dataLo;
  } dtx_bist_t;

  localparam dtx_bist_t BIST_NONE = '{mode: 8'h00, dataHi: 32'h00000000,
                                      dataLo: 32'h00000000};

  // Ending status reported by the link and physical layers.
  typedef struct packed {
    logic valid;
    logic err;
  } dtx_status_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    transport_idle_state,
    data_tx_setup_state,
    data_tx_dword_state,
    data_tx_end_state,
    selftest_tx_build_state,
    selftest_tx_status_state
  } dtx_state_t;

endpackage

/* rtl/dtx_word_buf.sv */
/*
  Two-entry buffer for link-bound words, valid and ready on both sides.
  Assumes one clock, an active-low asynchronous reset and a clock enable
  that freezes all state while low.
*/
`timescale 1ns/1ps
module dtx_word_buf
  import dtx_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      clkEn,
  input  wire logic      inValid,
  output logic           inReady,
  input  dtx_word_t      inWord,
  output logic           outValid,
  input  wire logic      outReady,
  output dtx_word_t      outWord
);

  dtx_word_t mem_q [2];
  dtx_word_t mem_d [2];
  logic      wrPtr_q, wrPtr_d;
  logic      rdPtr_q, rdPtr_d;
  logic [1:0] cnt_q, cnt_d;
  logic      doPush, doPop;

  // Two entries let a full-rate source keep going for one cycle of stall.
  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outWord  = mem_q[rdPtr_q];
  assign doPush   = clkEn && inValid && inReady;
  assign doPop    = clkEn && outValid && outReady;

  // Pointer and occupancy update.
  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    cnt_d   = cnt_q;
    if (doPush) begin
      mem_d[wrPtr_q] = inWord;
      wrPtr_d        = ~wrPtr_q;
    end
    if (doPop) begin
      rdPtr_d = ~rdPtr_q;
    end
    case ({doPush, doPop})
      2'b10:   cnt_d = cnt_q + 2'h1;
      2'b01:   cnt_d = cnt_q - 2'h1;
      default: cnt_d = cnt_q;
    endcase
  end

  // Storage registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= WORD_NONE;
      mem_q[1] <= WORD_NONE;
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      cnt_q    <= 2'h0;
    end else if (clkEn) begin
      mem_q    <= mem_d;
      wrPtr_q  <= wrPtr_d;
      rdPtr_q  <= rdPtr_d;
      cnt_q    <= cnt_d;
    end
  end

endmodule

/* rtl/dtx_transmit.sv */
/*
  Device transport transmit sequencer for the device-to-host data frame and
  the self-test activation frame, feeding the link layer through a buffer.
  Assumes the application layer, transmit FIFO and link layer share clk and
  that all inputs are synchronous to it.
  Requests are taken only while idle, so the application layer may hold
  them high until busy rises.
*/
`timescale 1ns/1ps
module dtx_transmit
  import dtx_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             dataReq,
  input  wire logic [LEN_W-1:0] dataLen,
  input  wire logic             abortReq,
  input  wire logic             bistReq,
  input  dtx_bist_t             bistContent,
  input  wire logic             bistResendEn,
  input  wire logic             fifoValid,
  output logic                  fifoReady,
  input  wire logic [DWORD_W-1:0] fifoData,
  output logic                  linkValid,
  input  wire logic             linkReady,
  output dtx_word_t             linkWord,
  output logic                  linkFrameStart,
  output logic                  linkFrameDone,
  output logic                  linkAbort,
  output logic                  linkErrReport,
  input  wire logic             linkIllegal,
  input  dtx_status_t           linkStatus,
  input  wire logic             linkEof,
  output logic                  busy,
  output logic                  dataDone,
  output logic                  dataErr,
  output logic                  selftestEnter,
  output logic [7:0]            selftestMode,
  output logic                  selftestFail
);

  // Sequencer state and frame bookkeeping.
  dtx_state_t       state_q, state_d;
  logic [LEN_W-1:0] lenRem_q, lenRem_d;
  logic             abortPend_q, abortPend_d;
  logic [BIDX_W-1:0] bidx_q, bidx_d;
  dtx_bist_t        bist_q, bist_d;

  // Registered strobes and levels toward the link and application layers.
  logic             start_q, start_d;
  logic             done_q, done_d;
  logic             abort_q, abort_d;
  logic             errRpt_q, errRpt_d;
  logic             dDone_q, dDone_d;
  logic             dErr_q, dErr_d;
  logic             stEnter_q, stEnter_d;
  logic [7:0]       stMode_q, stMode_d;
  logic             stFail_q, stFail_d;

  // Buffer-side handshake and shared decodes.
  logic             pushValid;
  logic             pushReady;
  dtx_word_t        pushWord;
  logic             takeFifo;
  logic             abortNow;

  // Words leave through the buffer, so a link stall never drops a word.
  // Its depth of two lets a full-rate source ride out a one-cycle stall.
  dtx_word_buf u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inWord   (pushWord),
    .outValid (linkValid),
    .outReady (linkReady),
    .outWord  (linkWord)
  );

  // An abort counts from the cycle it is raised; the latch only keeps it.
  assign abortNow = abortReq || abortPend_q;

  // A FIFO word is taken only when it can be pushed in the same cycle.
  // Holding back on a full buffer is what keeps a link stall from losing data.
  assign takeFifo  = clkEn && (state_q == data_tx_dword_state) && !linkIllegal &&
                     !abortNow && (lenRem_q != LEN_ZERO) && fifoValid &&
                     pushReady;
  assign fifoReady = takeFifo;

  // Sequencer next-state and output-pulse logic.
  // Strobes default low each cycle, so each one lasts a single cycle.
  always_comb begin
    state_d     = state_q;
    lenRem_d    = lenRem_q;
    abortPend_d = abortPend_q || abortReq;
    bidx_d      = bidx_q;
    bist_d      = bist_q;
    start_d     = 1'b0;
    done_d      = 1'b0;
    abort_d     = 1'b0;
    errRpt_d    = 1'b0;
    dDone_d     = 1'b0;
    dErr_d      = dErr_q;
    stEnter_d   = 1'b0;
    stMode_d    = stMode_q;
    stFail_d    = 1'b0;
    pushValid   = 1'b0;
    pushWord    = WORD_NONE;
    case (state_q)
      // Idle clears any leftover abort; a data request wins over self-test.
      transport_idle_state: begin
        abortPend_d = 1'b0;
        if (dataReq) begin
          state_d  = data_tx_setup_state;
          lenRem_d = dataLen;
          start_d  = 1'b1;
        end else if (bistReq) begin
          state_d = selftest_tx_build_state;
          bist_d  = bistContent;
          bidx_d  = BIDX_HDR;
          start_d = 1'b1;
        end
      end
      data_tx_setup_state: begin
        // The header goes out with the first FIFO word available.
        // The FIFO word itself stays put; it is taken in the dword state.
        if (abortNow) begin
          state_d = data_tx_end_state;
          abort_d = 1'b1;
        end else if (fifoValid && pushReady && clkEn) begin
          pushValid      = 1'b1;
          pushWord.data  = {HDR_PAD_DATA, FRAME_TYPE_DATA};
          pushWord.first = 1'b1;
          pushWord.last  = (lenRem_q == LEN_ZERO);
          // A header-only frame ends right here.
          if (lenRem_q == LEN_ZERO) begin
            state_d = data_tx_end_state;
            done_d  = 1'b1;
          end else begin
            state_d = data_tx_dword_state;
          end
        end
      end
      // One FIFO word per cycle while the buffer has room and words remain.
      data_tx_dword_state: begin
        if (linkIllegal) begin
          state_d = transport_idle_state;
        end else if (abortNow) begin
          state_d = data_tx_end_state;
          abort_d = 1'b1;
        end else if (takeFifo) begin
          pushValid     = 1'b1;
          pushWord.data = fifoData;
          pushWord.last = (lenRem_q == LEN_ONE);
          lenRem_d      = lenRem_q - LEN_ONE;
          if (lenRem_q == LEN_ONE) begin
            state_d = data_tx_end_state;
            done_d  = 1'b1;
          end
        end else begin
          // An empty FIFO or a full buffer simply waits here.
          state_d = data_tx_dword_state;
        end
      end
      // Normal frames end on the ending status; aborted ones on end-of-frame.
      data_tx_end_state: begin
        if (linkIllegal) begin
          state_d = transport_idle_state;
        end else if (abortPend_q) begin
          // An aborted frame ends on the link's end-of-frame, carrying status.
          // Error status rides on the same cycle as end-of-frame.
          if (linkEof) begin
            state_d  = transport_idle_state;
            errRpt_d = linkStatus.err;
            dErr_d   = linkStatus.err;
            dDone_d  = 1'b1;
          end
        end else if (abortReq) begin
          // A late abort is still signalled, then waits for end-of-frame.
          abort_d = 1'b1;
        end else if (linkStatus.valid) begin
          state_d  = transport_idle_state;
          errRpt_d = linkStatus.err;
          dErr_d   = linkStatus.err;
          dDone_d  = 1'b1;
        end
      end
      // Three words go out, one per cycle of buffer room, header first.
      selftest_tx_build_state: begin
        if (linkIllegal) begin
          state_d = transport_idle_state;
        end else if (pushReady && clkEn) begin
          pushValid      = 1'b1;
          pushWord.first = (bidx_q == BIDX_HDR);
          pushWord.last  = (bidx_q == BIDX_LAST);
          // The index picks the word; the last one also marks the frame end.
          case (bidx_q)
            BIDX_HDR: pushWord.data = {bist_q.mode, HDR_PAD_BIST, FRAME_TYPE_BIST};
            BIDX_HI:  pushWord.data = bist_q.dataHi;
            default:  pushWord.data = bist_q.dataLo;
          endcase
          if (bidx_q == BIDX_LAST) begin
            state_d = selftest_tx_status_state;
            done_d  = 1'b1;
          end else begin
            bidx_d = bidx_q + BIDX_ONE;
          end
        end
      end
      // Status decides between idle and an optional resend of the frame.
      // The link's illegal-transition notice is not honoured in this state.
      selftest_tx_status_state: begin
        if (linkStatus.valid) begin
          if (linkStatus.err && bistResendEn) begin
            // The latched content is reused, so the resend matches the first try.
            state_d = selftest_tx_build_state;
            bidx_d  = BIDX_HDR;
            start_d = 1'b1;
          end else begin
            // Clean or not, without a resend the frame is over.
            state_d   = transport_idle_state;
            stEnter_d = !linkStatus.err;
            stMode_d  = bist_q.mode;
            stFail_d  = linkStatus.err;
          end
        end
      end
      // Unused encodings fall back to idle rather than lock up.
      default: begin
        state_d = transport_idle_state;
      end
    endcase
  end

  // Sequencer registers; the clock enable freezes everything.
  // Reset values are all constants, so a mid-frame reset leaves nothing behind.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= transport_idle_state;
      lenRem_q    <= LEN_ZERO;
      abortPend_q <= 1'b0;
      bidx_q      <= BIDX_HDR;
      bist_q      <= BIST_NONE;
      start_q     <= 1'b0;
      done_q      <= 1'b0;
      abort_q     <= 1'b0;
      errRpt_q    <= 1'b0;
      dDone_q     <= 1'b0;
      dErr_q      <= 1'b0;
      stEnter_q   <= 1'b0;
      stMode_q    <= '0;
      stFail_q    <= 1'b0;
    end else if (clkEn) begin
      state_q     <= state_d;
      lenRem_q    <= lenRem_d;
      abortPend_q <= abortPend_d;
      bidx_q      <= bidx_d;
      bist_q      <= bist_d;
      start_q     <= start_d;
      done_q      <= done_d;
      abort_q     <= abort_d;
      errRpt_q    <= errRpt_d;
      dDone_q     <= dDone_d;
      dErr_q      <= dErr_d;
      stEnter_q   <= stEnter_d;
      stMode_q    <= stMode_d;
      stFail_q    <= stFail_d;
    end
  end

  // Pulses are registered so the link sees clean one-cycle strobes.
  assign linkFrameStart = start_q;
  assign linkFrameDone  = done_q;
  assign linkAbort      = abort_q;
  assign linkErrReport  = errRpt_q;

  // Application-side results; dataErr and selftestMode hold until the next frame of their own kind ends.
  assign dataDone       = dDone_q;
  assign dataErr        = dErr_q;
  assign selftestEnter  = stEnter_q;
  assign selftestMode   = stMode_q;
  assign selftestFail   = stFail_q;

  // Busy is decoded from the state register, so it has no extra lag.
  assign busy           = (state_q != transport_idle_state);

endmodule

/* rtl/dtx_transmit_note_end.sv */
/*
  Holds no logic; the sequencer and its word buffer live in their own files.
*/

/* testbench/dtx_transmit_props.sv */
/*
  Checker for the transmit sequencer, tied to its top-level ports only.
  Assumes one clock clk and the active-low asynchronous reset rst_n.
*/
`timescale 1ns/1ps
module dtx_transmit_props
  import dtx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic dataReq,
  input wire logic bistReq,
  input wire logic abortReq,
  input wire logic fifoValid,
  input wire logic fifoReady,
  input wire logic linkIllegal,
  input wire logic linkValid,
  input wire logic linkReady,
  input dtx_word_t linkWord,
  input wire logic linkFrameStart,
  input wire logic linkAbort,
  input wire logic linkErrReport,
  input wire logic busy,
  input wire logic dataDone,
  input wire logic dataErr,
  input wire logic selftestEnter,
  input wire logic selftestFail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A request seen while idle; the frame start rises in the same cycle as busy.
  sequence sIdleReq;
    !busy && (dataReq || bistReq) && clkEn;
  endsequence
  sequence sAbortSeen;
    abortReq && busy && clkEn;
  endsequence

  chk_req_busy: assert property (sIdleReq |=> busy)
    else $error("request in idle was not taken");
  chk_req_start: assert property (sIdleReq |=> ##[0:1] linkFrameStart)
    else $error("frame start not signalled to the link");
  chk_fifo_valid: assert property (fifoReady |-> fifoValid && busy && !linkIllegal)
    else $error("word taken from an empty FIFO or outside a frame");
  chk_word_hold: assert property (linkValid && !linkReady |=> linkValid && $stable(linkWord))
    else $error("stalled link word changed or vanished");
  chk_done_report: assert property (dataDone |-> linkErrReport == dataErr)
    else $error("error report disagrees with frame status");
  chk_done_idle: assert property (dataDone |-> !busy ##1 !dataDone)
    else $error("data frame end without return to idle");
  chk_abort_stop: assert property (sAbortSeen |=> !fifoReady [*2])
    else $error("FIFO word taken after abort");
  chk_abort_busy: assert property (linkAbort |-> busy && !dataDone)
    else $error("abort signalled outside a data frame");
  chk_enter_excl: assert property (selftestEnter |-> !selftestFail && !busy)
    else $error("self-test entry with failure or while busy");
endmodule

bind dtx_transmit dtx_transmit_props chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
  .dataReq(dataReq), .bistReq(bistReq), .abortReq(abortReq), .fifoValid(fifoValid),
  .fifoReady(fifoReady), .linkIllegal(linkIllegal), .linkValid(linkValid),
  .linkReady(linkReady), .linkWord(linkWord), .linkFrameStart(linkFrameStart),
  .linkAbort(linkAbort), .linkErrReport(linkErrReport), .busy(busy), .dataDone(dataDone),
  .dataErr(dataErr), .selftestEnter(selftestEnter), .selftestFail(selftestFail));

/* testbench/dtx_link_model.sv */
/*
  Link-layer stand-in that accepts words from the transmit buffer in order.
  Assumes the sequencer clock and reset; slow makes it accept one word in four.
*/
`timescale 1ns/1ps
module dtx_link_model
  import dtx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic linkValid,
  input  dtx_word_t linkWord,
  output logic      linkReady
);
  dtx_word_t  rxQ[$];
  logic [1:0] tick_q;

  // Ready moves only after an edge, so a stalled word must be held by the buffer.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 2'h0;
      linkReady <= 1'b0;
    end else begin
      tick_q <= tick_q + 2'h1;
      linkReady <= !slow || tick_q == 2'h3;
      if (linkValid && linkReady) rxQ.push_back(linkWord);
    end
  end
endmodule

/* testbench/device_data_bist_fis_transmit_tb.sv */
/*
  Self-checking bench for dtx_transmit: data, abort, illegal and self-test frames.
  Assumes the link model dtx_link_model and the bound property checker.
*/
`timescale 1ns/1ps
module device_data_bist_fis_transmit_tb
  import dtx_pkg::*;
;
  localparam dtx_bist_t BC = '{mode: 8'h3C, dataHi: 32'h1234ABCD, dataLo: 32'h0F0F5A5A};
  logic        clk, rst_n, clkEn, dataReq, abortReq, bistReq, bistResendEn, ok;
  logic        fifoValid, fifoReady, linkValid, linkReady, linkFrameStart, linkFrameDone;
  logic        linkAbort, linkErrReport, linkIllegal, linkEof, busy, dataDone, dataErr;
  logic        selftestEnter, selftestFail, gap, slow, clrSeen;
  logic [15:0] dataLen;
  logic [31:0] fifoData;
  logic [7:0]  selftestMode;
  logic [6:0]  seen;
  dtx_bist_t   bistContent;
  dtx_status_t linkStatus;
  dtx_word_t   linkWord;
  int          failures, n_tests, cycles, fIdx, fLen, nIdx;

  dtx_transmit dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .dataReq(dataReq),
    .dataLen(dataLen), .abortReq(abortReq), .bistReq(bistReq), .bistContent(bistContent),
    .bistResendEn(bistResendEn), .fifoValid(fifoValid), .fifoReady(fifoReady),
    .fifoData(fifoData), .linkValid(linkValid), .linkReady(linkReady), .linkWord(linkWord),
    .linkFrameStart(linkFrameStart), .linkFrameDone(linkFrameDone), .linkAbort(linkAbort),
    .linkErrReport(linkErrReport), .linkIllegal(linkIllegal), .linkStatus(linkStatus),
    .linkEof(linkEof), .busy(busy), .dataDone(dataDone), .dataErr(dataErr),
    .selftestEnter(selftestEnter), .selftestMode(selftestMode), .selftestFail(selftestFail));
  dtx_link_model link (.clk(clk), .rst_n(rst_n), .slow(slow), .linkValid(linkValid),
    .linkWord(linkWord), .linkReady(linkReady));

  // The 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // FIFO stand-in, pulse recorder and hang guard; a gap inverts the shown word each cycle, so garbage and the stale word alternate.
  always @(posedge clk) begin
    nIdx = busy ? fIdx + int'(fifoValid && fifoReady) : 0;
    ok = nIdx < fLen && !(gap && cycles[1]);
    fIdx <= nIdx;
    cycles <= cycles + 1;
    fifoValid <= ok;
    fifoData <= ok ? 32'(32'hA5000000 + nIdx) : (rst_n ? ~fifoData : 32'h00000000);
    seen <= ((clrSeen || !rst_n) ? 7'h00 : seen) | {selftestFail, selftestEnter, dataDone,
      linkErrReport, linkAbort, linkFrameStart, linkFrameDone};
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end

  task automatic chkWord(input dtx_word_t got, input dtx_word_t exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkFlag(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic dtx_word_t dWord(input int i, input int len);
    if (i == 0) return '{data: {HDR_PAD_DATA, FRAME_TYPE_DATA}, first: 1'b1, last: len == 0};
    return '{data: 32'(32'hA5000000 + i - 1), first: 1'b0, last: i == len};
  endfunction

  // The FIFO shows data even for a header-only frame, since the header waits on it.
  task automatic start(input logic d, input int len, input logic re);
    @(posedge clk);
    dataReq <= d;
    bistReq <= !d;
    dataLen <= 16'(len);
    bistContent <= BC;
    bistResendEn <= re;
    fLen <= (len == 0) ? 1 : len;
    clrSeen <= 1'b1;
    #1 link.rxQ.delete();
    @(posedge clk);
    dataReq <= 1'b0;
    bistReq <= 1'b0;
    clrSeen <= 1'b0;
  endtask

  task automatic drain(input int n);
    for (int k = 0; k < 400 && link.rxQ.size() < n; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  task automatic stat(input logic v, input logic e, input logic eof);
    @(posedge clk);
    linkStatus <= '{valid: v, err: e};
    linkEof <= eof;
    @(posedge clk);
    linkStatus <= '0;
    linkEof <= 1'b0;
    // Results are registered, so they stand one edge after the status is taken.
    @(posedge clk);
    #1;
  endtask

  task automatic t_data(input int len, input logic g, input logic s, input logic e);
    gap <= g;
    slow <= s;
    start(1'b1, len, 1'b0);
    drain(len + 1);
    for (int i = 0; i <= len; i++) chkWord(link.rxQ[i], dWord(i, len));
    chkFlag(32'(link.rxQ.size()), 32'(len + 1));
    stat(1'b1, e, 1'b0);
    chkFlag({dataErr, busy, seen}, {e, 1'b0, 2'b00, 1'b1, e, 3'b011});
    $display("data frame of %0d words ended", len);
  endtask

  task automatic t_abort();
    int n;
    gap <= 1'b0;
    slow <= 1'b0;
    start(1'b1, 12, 1'b0);
    drain(3);
    @(posedge clk) abortReq <= 1'b1;
    @(posedge clk) abortReq <= 1'b0;
    repeat (4) @(posedge clk);
    n = link.rxQ.size();
    repeat (6) @(posedge clk);
    chkFlag({busy, 15'(link.rxQ.size()), 16'(n < 13)}, {1'b1, 15'(n), 16'h0001});
    // With the clock enable low, end-of-frame must not end the frame.
    clkEn <= 1'b0;
    stat(1'b0, 1'b1, 1'b1);
    clkEn <= 1'b1;
    chkFlag({busy, dataDone}, 2'b10);
    stat(1'b0, 1'b1, 1'b1);
    chkFlag({dataErr, busy, seen}, {1'b1, 1'b0, 7'h1E});
    $display("aborted data frame ended");
  endtask

  task automatic t_ill();
    start(1'b1, 12, 1'b0);
    drain(3);
    @(posedge clk) linkIllegal <= 1'b1;
    @(posedge clk) linkIllegal <= 1'b0;
    #1 chkFlag(busy, 1'b0);
    repeat (3) @(posedge clk);
    chkFlag(seen, 7'h02);
    $display("illegal transition ended frame");
  endtask

  task automatic t_bist(input logic re, input logic e);
    dtx_word_t w[3];
    w[0] = '{data: {BC.mode, HDR_PAD_BIST, FRAME_TYPE_BIST}, first: 1'b1, last: 1'b0};
    w[1] = '{data: BC.dataHi, first: 1'b0, last: 1'b0};
    w[2] = '{data: BC.dataLo, first: 1'b0, last: 1'b1};
    slow <= 1'b1;
    start(1'b0, 0, re);
    drain(3);
    stat(1'b1, e, 1'b0);
    if (e && re) begin
      drain(6);
      stat(1'b1, 1'b0, 1'b0);
    end
    for (int i = 0; i < link.rxQ.size(); i++) chkWord(link.rxQ[i], w[i % 3]);
    chkFlag({busy, selftestMode, 4'(link.rxQ.size()), seen & 7'h63},
      {1'b0, BC.mode, (e && re) ? 4'h6 : 4'h3, e && !re, !e || re, 5'h03});
    $display("self-test frame ended");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every input starts defined; reset is held for twenty cycles.
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    {dataReq, abortReq, bistReq, bistResendEn, linkIllegal, linkEof, gap, slow} = '0;
    {dataLen, bistContent, linkStatus, clrSeen} = '0;
    {failures, n_tests, fLen} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_data(0, 1'b0, 1'b0, 1'b0);
    t_data(5, 1'b1, 1'b1, 1'b0);
    t_data(3, 1'b0, 1'b0, 1'b1);
    t_abort();
    t_ill();
    t_bist(1'b1, 1'b1);
    t_bist(1'b0, 1'b1);
    t_bist(1'b0, 1'b0);
    conclude();
  end
endmodule
